// ===== hw/stp_pkg.sv
// Constants and carrier types for the SDRAM timing, paging and throttle block.
// Assumes one 200 MHz core clock; all windows are counted in core clocks.
package stp_pkg;

  localparam int unsigned ROWS       = 8;
  localparam int unsigned BANKS      = 4;
  localparam int unsigned PAGE_W     = 13;
  localparam int unsigned ENGINES    = 2;
  localparam int unsigned ENG_WRITE  = 0;
  localparam int unsigned ENG_READ   = 1;
  localparam int unsigned CTRL_EN    = 2;
  localparam logic [2:0]  TIME_SLOW  = 3'h3;
  localparam logic [2:0]  TIME_FAST  = 3'h2;
  localparam logic [2:0]  LEAD_SLOW  = 3'h4;
  localparam logic [2:0]  LEAD_FAST  = 3'h3;
  localparam logic [2:0]  ADDR_FAST  = 3'h2;
  localparam logic [2:0]  ADDR_SLOW  = 3'h3;

  typedef enum logic {STP_MONITOR, STP_THROTTLE} stp_regime_t;

  typedef struct packed {
    logic column_latency_sel;
    logic row_to_col_delay_sel;
    logic row_precharge_sel;
    logic leadoff_select_timing;
  } stp_timing_t;

  typedef struct packed {
    logic [31:0] sample_window;
    logic [31:0] qw_threshold;
    logic [5:0]  throttle_time;
    logic [15:0] throttle_window;
    logic [15:0] throttle_budget;
    logic [2:0]  ctrl;
  } stp_eng_cfg_t;

  typedef struct packed {
    stp_regime_t regime;
    logic [31:0] win_cnt;
    logic [31:0] qw_cnt;
    logic [5:0]  mult_cnt;
    logic [15:0] tw_cnt;
    logic [15:0] used;
    logic        mask;
  } stp_eng_t;

  typedef struct packed {
    logic             valid;
    logic             write;
    logic [2:0]       row;
    logic [1:0]       bank;
    logic [PAGE_W-1:0] page;
    logic             sap_class;
    logic             posted_match;
  } stp_req_t;

  typedef struct packed {
    logic grant;
    logic write;
    logic autoprecharge;
    logic page_hit;
    logic page_conflict;
    logic refresh;
  } stp_grant_t;

endpackage

// ===== hw/stp_sdram_throttle.sv
// SDRAM timing selection, open-page tracking, arbitration gate and the
// write and read power-throttle engines.
// Assumes requests and quadword pulses come from logic on core_clk_in.
`timescale 1ns/100ps
module stp_sdram_throttle (
  input  wire logic                         core_clk_in,
  input  wire logic                         rstn_in,
  input  wire logic                         timing_wr_in,
  input  wire stp_pkg::stp_timing_t         timing_in,
  input  wire logic [1:0]                   thr_cfg_wr_in,
  input  wire stp_pkg::stp_eng_cfg_t        thr_cfg_in,
  input  wire logic                         lock_wr_in,
  input  wire logic                         serr_en_wr_in,
  input  wire logic                         serr_en_in,
  input  wire logic [7:0]                   two_bank_rows_in,
  input  wire logic                         selective_autoprecharge_in,
  input  wire stp_pkg::stp_req_t            req_in,
  input  wire logic                         refresh_req_in,
  input  wire logic                         write_qw_in,
  input  wire logic                         read_qw_in,
  output logic [2:0]                        cas_latency_out,
  output logic [2:0]                        row_to_col_out,
  output logic [2:0]                        precharge_out,
  output logic [2:0]                        leadoff_cs_clock_out,
  output logic [2:0]                        addr_cmd_clock_out,
  output stp_pkg::stp_grant_t               grant_out,
  output logic [1:0]                        throttling_out,
  output logic [1:0]                        masking_out,
  output logic                              throttle_settings_lock_out,
  output logic                              serr_out
);

  typedef struct packed {
    stp_pkg::stp_timing_t                         timing;
    stp_pkg::stp_eng_cfg_t [stp_pkg::ENGINES-1:0] cfg;
    stp_pkg::stp_eng_t [stp_pkg::ENGINES-1:0]     eng;
    logic                                         lock;
    logic                                         serr_en;
    logic                                         serr;
    logic [stp_pkg::ROWS-1:0][stp_pkg::BANKS-1:0] open_v;
    logic [stp_pkg::ROWS-1:0][stp_pkg::BANKS-1:0][stp_pkg::PAGE_W-1:0] open_pg;
    stp_pkg::stp_grant_t                          grant;
  } stp_state_t;

  stp_state_t state_r;
  stp_state_t state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Timing selects

  function automatic logic [2:0] sel_clocks(input logic slow);
    sel_clocks = slow ? stp_pkg::TIME_SLOW : stp_pkg::TIME_FAST;
  endfunction

  // Two-bank rows fold the bank field onto its low bit
  function automatic logic [1:0] bank_sel(input logic two, input logic [1:0] b);
    bank_sel = two ? {1'b0, b[0]} : b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // One throttle engine step; both engines share it so they cannot drift

  function automatic stp_pkg::stp_eng_t eng_step(input stp_pkg::stp_eng_cfg_t c,
                                                 input stp_pkg::stp_eng_t    e,
                                                 input logic                 qw);
    stp_pkg::stp_eng_t n;
    logic              win_end;
    logic              tw_end;
    n       = e;
    win_end = (e.win_cnt >= c.sample_window - 32'h1);
    tw_end  = (e.tw_cnt >= c.throttle_window - 16'h1);
    if (!c.ctrl[stp_pkg::CTRL_EN]) begin
      n = '0;
    end else begin
      n.win_cnt = win_end ? 32'h0 : e.win_cnt + 32'h1;
      unique case (e.regime)
        stp_pkg::STP_MONITOR: begin
          // Saturate so a long window cannot wrap below the threshold
          if (qw && e.qw_cnt != 32'hFFFFFFFF) begin
            n.qw_cnt = e.qw_cnt + 32'h1;
          end
          n.mask = 1'b0;
          if (win_end) begin
            // Judge on the updated count so a quadword in the last clock is not lost
            if (n.qw_cnt > c.qw_threshold) begin
              n.regime = stp_pkg::STP_THROTTLE;
            end
            n.qw_cnt   = 32'h0;
            n.mult_cnt = 6'h0;
            n.tw_cnt   = 16'h0;
            n.used     = 16'h0;
          end
        end
        stp_pkg::STP_THROTTLE: begin
          if (tw_end) begin
            n.tw_cnt = 16'h0;
            n.used   = 16'h0;
          end else begin
            n.tw_cnt = e.tw_cnt + 16'h1;
            if (qw && e.used != 16'hFFFF) begin
              n.used = e.used + 16'h1;
            end
          end
          n.mask = (n.used >= c.throttle_budget);
          if (win_end) begin
            n.mult_cnt = e.mult_cnt + 6'h1;
            if (e.mult_cnt + 6'h1 >= c.throttle_time) begin
              n = '0;
              n.regime = stp_pkg::STP_MONITOR;
            end
          end
        end
      endcase
    end
    eng_step = n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [1:0] bank;
    logic       hit;
    logic       open;
    logic       blocked;
    logic       ap;
    bank      = '0;
    hit       = 1'b0;
    open      = 1'b0;
    blocked   = 1'b0;
    ap        = 1'b0;
    state_nxt = state_r;

    if (timing_wr_in) begin
      state_nxt.timing = timing_in;
    end
    for (int i = 0; i < stp_pkg::ENGINES; i++) begin
      if (thr_cfg_wr_in[i] && !state_r.lock) begin
        state_nxt.cfg[i] = thr_cfg_in;
      end
    end
    if (lock_wr_in) begin
      state_nxt.lock = 1'b1;
    end
    if (serr_en_wr_in) begin
      state_nxt.serr_en = serr_en_in;
    end

    // Engines are stepped separately from their own quadword streams
    state_nxt.eng[stp_pkg::ENG_WRITE] = eng_step(state_r.cfg[stp_pkg::ENG_WRITE],
                                                 state_r.eng[stp_pkg::ENG_WRITE],
                                                 write_qw_in);
    state_nxt.eng[stp_pkg::ENG_READ]  = eng_step(state_r.cfg[stp_pkg::ENG_READ],
                                                 state_r.eng[stp_pkg::ENG_READ],
                                                 read_qw_in);
    state_nxt.serr = state_r.serr_en &&
                     (state_r.eng[0].regime == stp_pkg::STP_THROTTLE ||
                      state_r.eng[1].regime == stp_pkg::STP_THROTTLE);

    // Page lookup runs on the offered request, ahead of the DRAM access
    bank    = bank_sel(two_bank_rows_in[req_in.row], req_in.bank);
    open    = state_r.open_v[req_in.row][bank];
    hit     = open && (state_r.open_pg[req_in.row][bank] == req_in.page);
    blocked = state_r.eng[stp_pkg::ENG_READ].mask ||
              (state_r.eng[stp_pkg::ENG_WRITE].mask &&
               (req_in.write || req_in.posted_match));
    ap      = selective_autoprecharge_in && req_in.sap_class;

    state_nxt.grant = '0;
    if (refresh_req_in) begin
      // Refresh wins over masking; all banks precharge before it
      state_nxt.grant.refresh = 1'b1;
      state_nxt.open_v        = '0;
    end else if (req_in.valid && !blocked) begin
      state_nxt.grant.grant         = 1'b1;
      state_nxt.grant.write         = req_in.write;
      state_nxt.grant.autoprecharge = ap;
      state_nxt.grant.page_hit      = hit;
      state_nxt.grant.page_conflict = open && !hit;
      // Pages stay open on handoff except on autoprecharge cycles; no count of open rows is kept
      state_nxt.open_v[req_in.row][bank]  = !ap;
      state_nxt.open_pg[req_in.row][bank] = req_in.page;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cas_latency_out      <= stp_pkg::TIME_FAST;
      row_to_col_out       <= stp_pkg::TIME_FAST;
      precharge_out        <= stp_pkg::TIME_FAST;
      leadoff_cs_clock_out <= stp_pkg::LEAD_FAST;
      addr_cmd_clock_out   <= stp_pkg::ADDR_FAST;
    end else begin
      cas_latency_out      <= sel_clocks(state_nxt.timing.column_latency_sel);
      row_to_col_out       <= sel_clocks(state_nxt.timing.row_to_col_delay_sel);
      precharge_out        <= sel_clocks(state_nxt.timing.row_precharge_sel);
      leadoff_cs_clock_out <= state_nxt.timing.leadoff_select_timing ?
                              stp_pkg::LEAD_SLOW : stp_pkg::LEAD_FAST;
      addr_cmd_clock_out   <= state_nxt.timing.leadoff_select_timing ?
                              stp_pkg::ADDR_SLOW : stp_pkg::ADDR_FAST;
    end
  end

  always_comb begin
    grant_out                  = state_r.grant;
    throttle_settings_lock_out = state_r.lock;
    serr_out                   = state_r.serr;
    for (int i = 0; i < stp_pkg::ENGINES; i++) begin
      throttling_out[i] = (state_r.eng[i].regime == stp_pkg::STP_THROTTLE);
      masking_out[i]    = state_r.eng[i].mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_read_mask_req;
    state_r.eng[stp_pkg::ENG_READ].mask && req_in.valid && !refresh_req_in;
  endsequence

  sequence s_write_mask_wr;
    state_r.eng[stp_pkg::ENG_WRITE].mask && req_in.valid && req_in.write;
  endsequence

  sequence s_free_read;
    state_r.eng[stp_pkg::ENG_WRITE].mask && !state_r.eng[stp_pkg::ENG_READ].mask &&
    req_in.valid && !req_in.write && !req_in.posted_match && !refresh_req_in;
  endsequence

  chk_read_blocks_all: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    s_read_mask_req |=> !grant_out.grant)
    else $error("read mask let a cycle through");

  chk_write_blocks_wr: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    s_write_mask_wr |=> !grant_out.grant)
    else $error("write mask let a write through");

  chk_read_passes: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    s_free_read |=> grant_out.grant && !grant_out.write)
    else $error("independent read held by write mask");

  chk_refresh_kept: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    refresh_req_in |=> grant_out.refresh && !grant_out.grant)
    else $error("refresh not granted");

  chk_lock_freezes: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    state_r.lock |=> state_r.lock && $stable(state_r.cfg))
    else $error("locked throttle settings changed");

  chk_serr_enable: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    serr_en_wr_in |=> state_r.serr_en == $past(serr_en_in))
    else $error("error enable write lost");

  chk_disabled_idle: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !state_r.cfg[0].ctrl[stp_pkg::CTRL_EN] |=> !throttling_out[0] && !masking_out[0])
    else $error("disabled write engine active");

  chk_monitor_nomask: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !throttling_out[1] |-> !masking_out[1])
    else $error("mask raised while monitoring");

  chk_autoprecharge: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    req_in.valid && !refresh_req_in && !state_r.eng[1].mask && !state_r.eng[0].mask &&
    selective_autoprecharge_in && req_in.sap_class
    |=> grant_out.grant && grant_out.autoprecharge &&
        !state_r.open_v[$past(req_in.row)][$past(bank_sel(two_bank_rows_in[req_in.row],
                                                           req_in.bank))])
    else $error("selective cycle left page open");

  chk_leadoff_sel: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    timing_wr_in |=> leadoff_cs_clock_out ==
      ($past(timing_in.leadoff_select_timing) ? stp_pkg::LEAD_SLOW : stp_pkg::LEAD_FAST))
    else $error("leadoff clock wrong");

  // Last clock of an enabled engine's sampling window
  sequence s_win_last(i);
    state_r.cfg[i].ctrl[stp_pkg::CTRL_EN] &&
    state_r.eng[i].win_cnt == state_r.cfg[i].sample_window - 32'h1;
  endsequence

  // Same page offered again right after it was granted and left open
  sequence s_same_page;
    grant_out.grant && !grant_out.autoprecharge && req_in.valid && !refresh_req_in &&
    $stable(two_bank_rows_in) && req_in.row == $past(req_in.row) &&
    req_in.bank == $past(req_in.bank) && req_in.page == $past(req_in.page);
  endsequence

  chk_throttle_entry: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    s_win_last(0) ##0 (!throttling_out[0] &&
                       state_r.eng[0].qw_cnt > state_r.cfg[0].qw_threshold)
    |=> throttling_out[0])
    else $error("write engine missed throttling entry");

  chk_monitor_stays: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    s_win_last(1) ##0 (!throttling_out[1] &&
                       state_r.eng[1].qw_cnt < state_r.cfg[1].qw_threshold)
    |=> !throttling_out[1])
    else $error("read engine throttled below threshold");

  chk_throttle_exit: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    s_win_last(0) ##0 (throttling_out[0] &&
                       state_r.eng[0].mult_cnt + 6'h1 == state_r.cfg[0].throttle_time)
    |=> !throttling_out[0] && !masking_out[0])
    else $error("write throttling overran its time");

  // Budget check stays clear of both window ends, where other steps take over
  chk_budget_mask: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    throttling_out[0] && state_r.cfg[0].ctrl[stp_pkg::CTRL_EN] && write_qw_in &&
    state_r.eng[0].used + 16'h1 == state_r.cfg[0].throttle_budget &&
    state_r.eng[0].tw_cnt < state_r.cfg[0].throttle_window - 16'h1 &&
    state_r.eng[0].win_cnt < state_r.cfg[0].sample_window - 32'h1
    |=> masking_out[0])
    else $error("write budget spent without masking");

  chk_window_reload: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    throttling_out[0] && state_r.cfg[0].ctrl[stp_pkg::CTRL_EN] &&
    state_r.cfg[0].throttle_budget != 16'h0 &&
    state_r.eng[0].tw_cnt == state_r.cfg[0].throttle_window - 16'h1
    |=> !masking_out[0])
    else $error("write budget not reloaded");

  chk_write_nomask: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !throttling_out[0] |-> !masking_out[0])
    else $error("write mask raised while monitoring");

  chk_read_disabled: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    !state_r.cfg[1].ctrl[stp_pkg::CTRL_EN] |=> !throttling_out[1] && !masking_out[1])
    else $error("disabled read engine active");

  chk_page_reopen: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    s_same_page |=> !grant_out.grant || grant_out.page_hit)
    else $error("reopened page missed the open table");

endmodule

// ===== dv/stp_sw_model.sv
// Software side model: programs both throttle engines, then locks.
// Assumes start_in rises once after reset; config values come from the bench.
`timescale 1ns/100ps
module stp_sw_model (
  input  wire logic                  core_clk_in,
  input  wire logic                  start_in,
  input  wire stp_pkg::stp_eng_cfg_t wcfg_in,
  input  wire stp_pkg::stp_eng_cfg_t rcfg_in,
  output logic [1:0]                 thr_cfg_wr_out,
  output stp_pkg::stp_eng_cfg_t      thr_cfg_out,
  output logic                       lock_wr_out,
  output logic                       done_out
);
  task put(input logic [1:0] sel, input stp_pkg::stp_eng_cfg_t c, input logic en);
    @(posedge core_clk_in) #1;
    thr_cfg_out      = c;
    thr_cfg_out.ctrl = {en, 2'h0};
    thr_cfg_wr_out   = sel;
    @(posedge core_clk_in) #1;
    thr_cfg_wr_out   = 2'h0;
  endtask

  initial begin
    thr_cfg_wr_out = 2'h0;
    thr_cfg_out    = '0;
    lock_wr_out    = 1'b0;
    done_out       = 1'b0;
    @(posedge start_in);
    put(2'h1, wcfg_in, 1'b0);
    put(2'h2, rcfg_in, 1'b0);
    put(2'h1, wcfg_in, 1'b1);
    put(2'h2, rcfg_in, 1'b1);
    @(posedge core_clk_in) #1;
    lock_wr_out = 1'b1;
    @(posedge core_clk_in) #1;
    lock_wr_out = 1'b0;
    // Late overwrite with zeros: a locked device must drop it
    put(2'h3, '0, 1'b0);
    // Nonblocking: the bench polls at this same offset after the edge
    done_out <= 1'b1;
  end
endmodule

// ===== dv/tb_stp_sdram_throttle.sv
// Bench for the timing, paging and throttle block, one task a scenario.
// Assumes the software model owns the throttle config and lock ports.
`timescale 1ns/100ps
module tb_stp_sdram_throttle;
  logic                  core_clk_in = 1'b0;
  logic                  rstn_in     = 1'b0;
  logic                  timing_wr_in = 1'b0;
  logic [3:0]            timing_in   = 4'h0;
  logic                  serr_en_wr_in = 1'b0;
  logic                  serr_en_in  = 1'b0;
  logic [7:0]            two_bank_rows_in = 8'h04;
  logic                  sap_in      = 1'b0;
  stp_pkg::stp_req_t     req_in      = '0;
  logic                  refresh_req_in = 1'b0;
  logic                  write_qw_in = 1'b0;
  logic                  read_qw_in  = 1'b0;
  logic                  start       = 1'b0;
  stp_pkg::stp_eng_cfg_t wcfg        = '{32'h28, 32'h3, 6'h1, 16'h10, 16'h2, 3'h4};
  stp_pkg::stp_eng_cfg_t rcfg        = '{32'h28, 32'h3, 6'h1, 16'h10, 16'h1, 3'h4};
  logic [1:0]            cfg_wr;
  stp_pkg::stp_eng_cfg_t cfg;
  logic                  lock_wr;
  logic                  done;
  logic [2:0]            cas, rc, pre, lead, addr;
  stp_pkg::stp_grant_t   grant_out;
  logic [1:0]            thr, msk;
  logic                  lock, serr_out;
  logic [4:0]            st;
  stp_pkg::stp_grant_t   g;
  int                    errors = 0;
  int                    checks = 0;

  assign st = {done, msk, thr};
  always #2.5 core_clk_in = ~core_clk_in;

  stp_sdram_throttle stp_sdram_throttle_i (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .timing_wr_in(timing_wr_in),
    .timing_in(timing_in), .thr_cfg_wr_in(cfg_wr), .thr_cfg_in(cfg),
    .lock_wr_in(lock_wr), .serr_en_wr_in(serr_en_wr_in), .serr_en_in(serr_en_in),
    .two_bank_rows_in(two_bank_rows_in), .selective_autoprecharge_in(sap_in),
    .req_in(req_in), .refresh_req_in(refresh_req_in), .write_qw_in(write_qw_in),
    .read_qw_in(read_qw_in), .cas_latency_out(cas), .row_to_col_out(rc),
    .precharge_out(pre), .leadoff_cs_clock_out(lead), .addr_cmd_clock_out(addr),
    .grant_out(grant_out), .throttling_out(thr), .masking_out(msk),
    .throttle_settings_lock_out(lock), .serr_out(serr_out));

  stp_sw_model stp_sw_model_i (
    .core_clk_in(core_clk_in), .start_in(start), .wcfg_in(wcfg), .rcfg_in(rcfg),
    .thr_cfg_wr_out(cfg_wr), .thr_cfg_out(cfg), .lock_wr_out(lock_wr),
    .done_out(done));

  ////////////////////////////////////////////////////////////////////////////
  task give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge core_clk_in) #1;
  endtask

  // Bounded wait on one status bit; running out ends the run
  task wait_st(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (st[b] !== v && n < lim) begin
      tick(1);
      n++;
    end
    if (st[b] !== v) begin
      errors++;
      $display("[ERR] %0t wait on status bit %0d ran out", $time, b);
      give_verdict();
    end
  endtask

  // Offer held over one sampling edge; registered grant read just after it
  task offer(input logic w, input logic [2:0] r, input logic [1:0] b,
             input logic [12:0] p, input logic s, input logic m, input logic rf);
    req_in         = {1'b1, w, r, b, p, s, m};
    refresh_req_in = rf;
    tick(1);
    g              = grant_out;
  endtask

  task idle();
    req_in         = '0;
    refresh_req_in = 1'b0;
    tick(1);
  endtask

  task qw(input logic w, input int n);
    repeat (n) begin
      write_qw_in = w;
      read_qw_in  = !w;
      tick(1);
    end
    write_qw_in = 1'b0;
    read_qw_in  = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_timing();
    logic [14:0] e;
    chk({cas, rc, pre, lead, addr}, {3'h2, 3'h2, 3'h2, 3'h3, 3'h2});
    for (int i = 0; i < 16; i++) begin
      timing_in    = 4'(i);
      timing_wr_in = 1'b1;
      tick(1);
      timing_wr_in = 1'b0;
      tick(1);
      e = {3'h2 + 3'(i / 8), 3'h2 + 3'((i / 4) % 2), 3'h2 + 3'((i / 2) % 2),
           3'h3 + 3'(i % 2), 3'h2 + 3'(i % 2)};
      chk({cas, rc, pre, lead, addr}, e);
    end
    $display("test timing done");
  endtask

  task t_page();
    offer(1'b0, 3'h1, 2'h1, 13'h0AA, 1'b0, 1'b0, 1'b0);
    chk(g, 6'h20);
    offer(1'b0, 3'h1, 2'h1, 13'h0AA, 1'b0, 1'b0, 1'b0);
    chk(g, 6'h24);
    offer(1'b1, 3'h1, 2'h1, 13'h0AB, 1'b0, 1'b0, 1'b0);
    chk(g, 6'h32);
    offer(1'b0, 3'h1, 2'h1, 13'h0AB, 1'b0, 1'b0, 1'b0);
    chk(g, 6'h24);
    offer(1'b0, 3'h2, 2'h1, 13'h055, 1'b0, 1'b0, 1'b0);
    offer(1'b0, 3'h2, 2'h3, 13'h055, 1'b0, 1'b0, 1'b0);
    chk(g, 6'h24);
    offer(1'b0, 3'h1, 2'h1, 13'h0AB, 1'b0, 1'b0, 1'b0);
    chk(g, 6'h24);
    offer(1'b0, 3'h0, 2'h0, 13'h000, 1'b0, 1'b0, 1'b1);
    chk(g.refresh, 1'b1);
    offer(1'b0, 3'h1, 2'h1, 13'h0AB, 1'b0, 1'b0, 1'b0);
    chk(g, 6'h20);
    sap_in = 1'b1;
    offer(1'b0, 3'h3, 2'h2, 13'h005, 1'b1, 1'b0, 1'b0);
    chk(g, 6'h28);
    offer(1'b0, 3'h3, 2'h2, 13'h005, 1'b0, 1'b0, 1'b0);
    chk(g, 6'h20);
    offer(1'b0, 3'h3, 2'h2, 13'h005, 1'b0, 1'b0, 1'b0);
    chk(g, 6'h24);
    idle();
    $display("test page done");
  endtask

  task t_write_thr();
    qw(1'b1, 8);
    tick(90);
    chk(st, 5'h00);
    start = 1'b1;
    wait_st(4, 1'b1, 40);
    serr_en_in    = 1'b1;
    serr_en_wr_in = 1'b1;
    tick(1);
    serr_en_wr_in = 1'b0;
    chk(lock, 1'b1);
    qw(1'b1, 8);
    wait_st(0, 1'b1, 90);
    chk(st, 5'h11);
    tick(2);
    chk(serr_out, 1'b1);
    qw(1'b1, 2);
    wait_st(2, 1'b1, 4);
    offer(1'b1, 3'h4, 2'h0, 13'h010, 1'b0, 1'b0, 1'b0);
    chk(g.grant, 1'b0);
    offer(1'b0, 3'h4, 2'h1, 13'h010, 1'b0, 1'b0, 1'b0);
    chk(g.grant, 1'b1);
    offer(1'b0, 3'h4, 2'h1, 13'h010, 1'b0, 1'b1, 1'b0);
    chk(g.grant, 1'b0);
    offer(1'b0, 3'h0, 2'h0, 13'h000, 1'b0, 1'b0, 1'b1);
    chk(g.refresh, 1'b1);
    idle();
    wait_st(2, 1'b0, 16);
    chk(st, 5'h11);
    // Throttling began at a window end and lasts exactly one 40-clock window
    tick(23);
    chk(st[0], 1'b1);
    wait_st(0, 1'b0, 1);
    qw(1'b1, 3);
    tick(90);
    chk(st, 5'h10);
    $display("test write throttle done");
  endtask

  task t_read_thr();
    qw(1'b0, 8);
    wait_st(1, 1'b1, 90);
    chk(st, 5'h12);
    qw(1'b0, 1);
    wait_st(3, 1'b1, 4);
    offer(1'b0, 3'h5, 2'h0, 13'h020, 1'b0, 1'b0, 1'b0);
    chk(g.grant, 1'b0);
    offer(1'b1, 3'h5, 2'h0, 13'h020, 1'b0, 1'b0, 1'b0);
    chk(g.grant, 1'b0);
    offer(1'b0, 3'h0, 2'h0, 13'h000, 1'b0, 1'b0, 1'b1);
    chk(g.refresh, 1'b1);
    idle();
    $display("test read throttle done");
  endtask

  initial begin
    repeat (6) @(posedge core_clk_in);
    #1 rstn_in = 1'b1;
    tick(1);
    t_timing();
    t_page();
    t_write_thr();
    t_read_thr();
    give_verdict();
  end
endmodule
